// *** hdl/ceh_err_counter.sv ***
/*
  Saturating correctable error counter with threshold flag.
  Assumes increments and clear come from logic on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module ceh_err_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events and configuration
  input wire logic [1:0] inc_i,
  input wire logic clr_i,
  input wire logic [ceh_pkg::CNT_W-1:0] thresh_i,
  // Status
  output logic reached_o,
  output logic [ceh_pkg::CNT_W-1:0] count_o
);

  typedef struct packed {
    logic [ceh_pkg::CNT_W-1:0] cnt;
  } ceh_cnt_state_t;

  ceh_cnt_state_t s_q;
  ceh_cnt_state_t s_d;

  // Next count: saturate, clear restarts from the same-cycle increment
  always_comb begin
    logic [ceh_pkg::CNT_W:0] sum;
    sum = {1'b0, s_q.cnt} + {{(ceh_pkg::CNT_W-1){1'b0}}, inc_i};
    s_d = s_q;
    if (clr_i) begin
      s_d.cnt = {{(ceh_pkg::CNT_W-2){1'b0}}, inc_i};
    end else if (sum[ceh_pkg::CNT_W]) begin
      s_d.cnt = ceh_pkg::CNT_MAX;
    end else begin
      s_d.cnt = sum[ceh_pkg::CNT_W-1:0];
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q.cnt <= ceh_pkg::CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Threshold compare, zero threshold disables
  assign reached_o = (thresh_i != ceh_pkg::THRESH_OFF) && (s_q.cnt >= thresh_i);
  assign count_o = s_q.cnt;

endmodule // ceh_err_counter

`default_nettype wire

// *** hdl/ceh_handler.sv ***
/*
  Correctable error handler of the core: counts errors of the
  instruction cache and both local memories, raises the local
  correctable interrupt, orders refetch flushes and writes corrected
  words back. Assumes all inputs come from logic on clk_i, ECC
  decoders outside deliver corrected data alongside each error flag,
  and memory ports accept write-backs with a valid/ready handshake.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Count every instruction cache correctable fetch error
// - Cache counter at threshold raises local interrupt
// - Count fetches whether or not they execute
// - Cache error: invalidate set, refetch flush, pipeline flush
// - Then refill the cache line from bus
// - Single and double cache errors recover alike
// - Count instr memory errors, interrupt at threshold
// - Instr fetch error: flush, write back, refetch
// - Instr fetch errors flushed, never corrected in-line
// - Count data memory errors, interrupt at threshold
// - Data memory errors corrected and written back
// - Data memory handling only for non-speculative accesses
// - DMA instr memory reads corrected, written back
// - DMA data memory reads counted, corrected, written back
// - Counters record no addresses
// - DMA writes never checked nor reported
module ceh_handler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction cache fetch errors
  input wire logic ic_err_i,
  input wire logic ic_double_i,
  input wire logic [ceh_pkg::SET_W-1:0] ic_set_i,
  // Instruction memory fetch errors
  input wire ceh_pkg::ceh_err_t ilm_fetch_i,
  // Data memory load/store errors
  input wire ceh_pkg::ceh_err_t dlm_ls_i,
  input wire logic dlm_nonspec_i,
  // DMA reads and writes
  input wire ceh_pkg::ceh_err_t dma_ilm_rd_i,
  input wire ceh_pkg::ceh_err_t dma_dlm_rd_i,
  input wire logic dma_ilm_wr_i,
  input wire logic dma_dlm_wr_i,
  // Counter configuration and clears
  input wire logic [ceh_pkg::CNT_W-1:0] ic_thresh_i,
  input wire logic [ceh_pkg::CNT_W-1:0] ilm_thresh_i,
  input wire logic [ceh_pkg::CNT_W-1:0] dlm_thresh_i,
  input wire logic ic_cnt_clr_i,
  input wire logic ilm_cnt_clr_i,
  input wire logic dlm_cnt_clr_i,
  // Cache invalidate and refill
  output logic ic_inv_o,
  output logic [ceh_pkg::SET_W-1:0] ic_inv_set_o,
  output logic ic_refill_req_o,
  input wire logic ic_refill_ack_i,
  // Pipeline control
  output logic refetch_pc_flush_o,
  output logic pipe_flush_o,
  output logic ilm_refetch_o,
  output logic [ceh_pkg::ADDR_W-1:0] ilm_refetch_addr_o,
  // Write-back ports
  output ceh_pkg::ceh_wb_t ilm_wb_o,
  input wire logic ilm_wb_ready_i,
  output ceh_pkg::ceh_wb_t dlm_wb_o,
  input wire logic dlm_wb_ready_i,
  // Back-pressure to error sources
  output logic dma_ilm_hold_o,
  output logic dma_dlm_hold_o,
  output logic dlm_ls_hold_o,
  // Counts and interrupt
  output logic [ceh_pkg::CNT_W-1:0] ic_count_o,
  output logic [ceh_pkg::CNT_W-1:0] ilm_count_o,
  output logic [ceh_pkg::CNT_W-1:0] dlm_count_o,
  output logic corr_irq_o
);

  typedef struct packed {
    ceh_pkg::ceh_fetch_state_t fs;
    logic [ceh_pkg::SET_W-1:0] ic_set;
    logic [ceh_pkg::ADDR_W-1:0] f_addr;
    logic [ceh_pkg::DATA_W-1:0] f_data;
    ceh_pkg::ceh_wb_t ilm_wb;
    ceh_pkg::ceh_wb_t dlm_wb;
    logic inv;
    logic refetch_pc_flush;
    logic pflush;
    logic refill;
    logic refetch;
    logic irq;
  } ceh_state_t;

  ceh_state_t s_q;
  ceh_state_t s_d;

  logic ic_hit;
  logic ilm_f_hit;
  logic dma_i_hit;
  logic dma_i_take;
  logic dlm_ls_hit;
  logic dlm_ls_take;
  logic dma_d_hit;
  logic dma_d_take;
  logic [1:0] ic_inc;
  logic [1:0] ilm_inc;
  logic [1:0] dlm_inc;
  logic ic_reached;
  logic ilm_reached;
  logic dlm_reached;

  // Error qualification
  assign ic_hit = ic_err_i;
  assign ilm_f_hit = ilm_fetch_i.err;
  assign dma_i_hit = dma_ilm_rd_i.err && !dma_ilm_wr_i;
  assign dma_d_hit = dma_dlm_rd_i.err && !dma_dlm_wr_i;
  assign dlm_ls_hit = dlm_ls_i.err && dlm_nonspec_i;

  // Write-back slot arbitration, load/store before DMA
  assign dlm_ls_take = dlm_ls_hit && !s_q.dlm_wb.valid;
  assign dma_d_take = dma_d_hit && !s_q.dlm_wb.valid && !dlm_ls_hit;
  assign dma_i_take = dma_i_hit && !s_q.ilm_wb.valid;

  // Back-pressure while a slot is occupied, and on DMA data reads while a load/store takes the slot
  assign dlm_ls_hold_o = dlm_ls_hit && s_q.dlm_wb.valid;
  assign dma_dlm_hold_o = dma_d_hit && !dma_d_take;
  assign dma_ilm_hold_o = dma_i_hit && !dma_i_take;

  // Counter increments, accepted events only
  assign ic_inc = {1'b0, ic_hit};
  assign ilm_inc = 2'(ilm_f_hit) + 2'(dma_i_take);
  assign dlm_inc = 2'(dlm_ls_take) + 2'(dma_d_take);

  // Instruction cache counter
  ceh_err_counter u_ic_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(ic_inc),
    .clr_i(ic_cnt_clr_i),
    .thresh_i(ic_thresh_i),
    .reached_o(ic_reached),
    .count_o(ic_count_o)
  );

  // Instruction memory counter
  ceh_err_counter u_ilm_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(ilm_inc),
    .clr_i(ilm_cnt_clr_i),
    .thresh_i(ilm_thresh_i),
    .reached_o(ilm_reached),
    .count_o(ilm_count_o)
  );

  // Data memory counter
  ceh_err_counter u_dlm_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .inc_i(dlm_inc),
    .clr_i(dlm_cnt_clr_i),
    .thresh_i(dlm_thresh_i),
    .reached_o(dlm_reached),
    .count_o(dlm_count_o)
  );

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.inv = 1'b0;
    s_d.refetch_pc_flush = 1'b0;
    s_d.pflush = 1'b0;
    s_d.refetch = 1'b0;

    // Local interrupt from any counter at threshold
    s_d.irq = ic_reached || ilm_reached || dlm_reached;

    // Retire written-back words
    if (s_q.ilm_wb.valid && ilm_wb_ready_i) begin
      s_d.ilm_wb.valid = 1'b0;
    end
    if (s_q.dlm_wb.valid && dlm_wb_ready_i) begin
      s_d.dlm_wb.valid = 1'b0;
    end

    // DMA read of instruction memory, corrected word written back
    if (dma_i_take) begin
      s_d.ilm_wb.valid = 1'b1;
      s_d.ilm_wb.addr = dma_ilm_rd_i.addr;
      s_d.ilm_wb.data = dma_ilm_rd_i.data;
      s_d.ilm_wb.chk = ceh_pkg::ceh_ecc_gen(dma_ilm_rd_i.data);
    end

    // Data memory: in-line corrected word written back
    if (dlm_ls_take) begin
      s_d.dlm_wb.valid = 1'b1;
      s_d.dlm_wb.addr = dlm_ls_i.addr;
      s_d.dlm_wb.data = dlm_ls_i.data;
      s_d.dlm_wb.chk = ceh_pkg::ceh_ecc_gen(dlm_ls_i.data);
    end else if (dma_d_take) begin
      s_d.dlm_wb.valid = 1'b1;
      s_d.dlm_wb.addr = dma_dlm_rd_i.addr;
      s_d.dlm_wb.data = dma_dlm_rd_i.data;
      s_d.dlm_wb.chk = ceh_pkg::ceh_ecc_gen(dma_dlm_rd_i.data);
    end

    // Fetch side recovery sequence
    unique case (s_q.fs)
      ceh_pkg::FS_IDLE: begin
        if (ilm_f_hit) begin
          s_d.f_addr = ilm_fetch_i.addr;
          s_d.f_data = ilm_fetch_i.data;
          s_d.fs = ceh_pkg::FS_ILM_FLUSH;
        end else if (ic_hit) begin
          s_d.ic_set = ic_set_i;
          s_d.fs = ceh_pkg::FS_IC_FLUSH;
        end
      end
      ceh_pkg::FS_IC_FLUSH: begin
        s_d.inv = 1'b1;
        s_d.refetch_pc_flush = 1'b1;
        s_d.pflush = 1'b1;
        s_d.refill = 1'b1;
        s_d.fs = ceh_pkg::FS_IC_REFILL;
      end
      ceh_pkg::FS_IC_REFILL: begin
        if (ic_refill_ack_i) begin
          s_d.refill = 1'b0;
          s_d.fs = ceh_pkg::FS_IDLE;
        end
      end
      ceh_pkg::FS_ILM_FLUSH: begin
        s_d.refetch_pc_flush = 1'b1;
        s_d.pflush = 1'b1;
        s_d.fs = ceh_pkg::FS_ILM_WB;
      end
      ceh_pkg::FS_ILM_WB: begin
        // Wait for a free slot; DMA already in it goes first
        if (!s_q.ilm_wb.valid && !dma_i_take) begin
          s_d.ilm_wb.valid = 1'b1;
          s_d.ilm_wb.addr = s_q.f_addr;
          s_d.ilm_wb.data = s_q.f_data;
          s_d.ilm_wb.chk = ceh_pkg::ceh_ecc_gen(s_q.f_data);
          s_d.fs = ceh_pkg::FS_ILM_REFETCH;
        end
      end
      ceh_pkg::FS_ILM_REFETCH: begin
        // Refetch only once the corrected word is stored
        if (!s_q.ilm_wb.valid) begin
          s_d.refetch = 1'b1;
          s_d.fs = ceh_pkg::FS_IDLE;
        end
      end
      default: begin
        s_d.fs = ceh_pkg::FS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from the state register
  assign ic_inv_o = s_q.inv;
  assign ic_inv_set_o = s_q.ic_set;
  assign ic_refill_req_o = s_q.refill;
  assign refetch_pc_flush_o = s_q.refetch_pc_flush;
  assign pipe_flush_o = s_q.pflush;
  assign ilm_refetch_o = s_q.refetch;
  assign ilm_refetch_addr_o = s_q.f_addr;
  assign ilm_wb_o = s_q.ilm_wb;
  assign dlm_wb_o = s_q.dlm_wb;
  assign corr_irq_o = s_q.irq;

endmodule // ceh_handler

`default_nettype wire

// *** hdl/ceh_pkg.sv ***
/*
  Shared constants and carrier types of the correctable error handler.
  Assumes SECDED code words of 32 data bits and 7 check bits.
*/
package ceh_pkg;

  // Data path widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CHK_W = 7;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned SET_W = 8;

  // Error counters
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] THRESH_OFF = 16'h0000;

  // Check bit masks over the data word
  localparam logic [DATA_W-1:0] CHK_MASK_0 = 32'h56AA_AD5B;
  localparam logic [DATA_W-1:0] CHK_MASK_1 = 32'h9B33_366D;
  localparam logic [DATA_W-1:0] CHK_MASK_2 = 32'hE3C3_C78E;
  localparam logic [DATA_W-1:0] CHK_MASK_3 = 32'h03FC_07F0;
  localparam logic [DATA_W-1:0] CHK_MASK_4 = 32'h03FF_F800;
  localparam logic [DATA_W-1:0] CHK_MASK_5 = 32'hFC00_0000;
  localparam int unsigned CHK_ALL = 6;

  // Recovery sequence of the fetch side
  typedef enum logic [2:0] {
    FS_IDLE,
    FS_IC_FLUSH,
    FS_IC_REFILL,
    FS_ILM_FLUSH,
    FS_ILM_WB,
    FS_ILM_REFETCH
  } ceh_fetch_state_t;

  // Corrected word awaiting write-back
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0] chk;
  } ceh_wb_t;

  // Error report from a read port
  typedef struct packed {
    logic err;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ceh_err_t;

  // Fresh check bits for a corrected word
  function automatic logic [CHK_W-1:0] ceh_ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c[0] = ^(d & CHK_MASK_0);
    c[1] = ^(d & CHK_MASK_1);
    c[2] = ^(d & CHK_MASK_2);
    c[3] = ^(d & CHK_MASK_3);
    c[4] = ^(d & CHK_MASK_4);
    c[5] = ^(d & CHK_MASK_5);
    c[CHK_ALL] = (^d) ^ (^c[5:0]);
    return c;
  endfunction

endpackage

// *** test/ceh_handler_properties.sv ***
/*
  Port checks of the correctable error handler.
  Assumes one clock domain and the asynchronous high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module ceh_handler_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Inputs watched
  input wire logic ic_err_i,
  input wire logic ic_cnt_clr_i,
  input wire logic ic_refill_ack_i,
  input wire logic dlm_wb_ready_i,
  input wire ceh_pkg::ceh_err_t dlm_ls_i,
  input wire logic dlm_nonspec_i,
  input wire ceh_pkg::ceh_err_t dma_dlm_rd_i,
  input wire logic dlm_cnt_clr_i,
  input wire logic [15:0] dlm_thresh_i,
  // Outputs watched
  input wire logic ic_inv_o,
  input wire logic refetch_pc_flush_o,
  input wire logic pipe_flush_o,
  input wire logic ic_refill_req_o,
  input wire ceh_pkg::ceh_wb_t dlm_wb_o,
  input wire logic dlm_ls_hold_o,
  input wire logic [15:0] ic_count_o,
  input wire logic [15:0] dlm_count_o,
  input wire logic corr_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Recovery steps of a cache error
  sequence s_flush;
    ic_inv_o && refetch_pc_flush_o && pipe_flush_o && ic_refill_req_o;
  endsequence
  sequence s_refill_end;
    ic_refill_ack_i ##1 !ic_refill_req_o;
  endsequence

  a_ic_count_inc: assert property (ic_err_i && !ic_cnt_clr_i && ic_count_o != 16'hFFFF
    |=> ic_count_o == $past(ic_count_o) + 16'h0001) else $error("cache count missed");
  a_ic_inv_cause: assert property (ic_inv_o |-> $past(ic_err_i, 2))
    else $error("invalidate without cache error");
  a_ic_flush_set: assert property (ic_inv_o |-> s_flush)
    else $error("cache recovery incomplete");
  a_refill_hold: assert property (ic_refill_req_o && !ic_refill_ack_i |=> ic_refill_req_o)
    else $error("refill dropped early");
  a_refill_drop: assert property (ic_refill_req_o && ic_refill_ack_i |-> s_refill_end)
    else $error("refill not released");
  a_dlm_wb_hold: assert property (dlm_wb_o.valid && !dlm_wb_ready_i
    |=> dlm_wb_o.valid && $stable(dlm_wb_o)) else $error("write-back not held");
  a_dlm_wb_take: assert property (dlm_ls_i.err && dlm_nonspec_i && !dlm_ls_hold_o
    |=> dlm_wb_o.valid) else $error("no data write-back");
  a_spec_ignored: assert property (dlm_ls_i.err && !dlm_nonspec_i && !dma_dlm_rd_i.err
    && !dlm_cnt_clr_i |=> $stable(dlm_count_o)) else $error("speculative error counted");
  a_irq_thresh: assert property (dlm_thresh_i != 16'h0000 && dlm_count_o >= dlm_thresh_i
    |=> corr_irq_o) else $error("interrupt missing");
  a_ic_saturate: assert property (ic_count_o == 16'hFFFF && !ic_cnt_clr_i
    |=> ic_count_o == 16'hFFFF) else $error("counter wrapped");
endmodule // ceh_handler_properties

bind ceh_handler ceh_handler_properties chk_u (.*);

`default_nettype wire

// *** test/ceh_mem_model.sv ***
/*
  Far side: cache refill over the bus and the two memory write ports.
  Assumes requests and write-backs come from the handler on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module ceh_mem_model (
  // Clock, reset and pacing
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // Requests from the handler
  input wire logic refill_req_i,
  input wire logic ilm_wb_i,
  input wire logic dlm_wb_i,
  // Answers
  output logic refill_ack_o,
  output logic ilm_ready_o,
  output logic dlm_ready_o
);
  logic [2:0] tick_q;
  logic done_q;

  // Slow mode accepts only one cycle in eight
  assign ilm_ready_o = ilm_wb_i && (!slow_i || tick_q == 3'h0);
  assign dlm_ready_o = dlm_wb_i && (!slow_i || tick_q == 3'h0);

  // One refill answer per request, bus data already corrected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_q <= 3'h0;
      done_q <= 1'b0;
      refill_ack_o <= 1'b0;
    end else begin
      tick_q <= tick_q + 3'h1;
      refill_ack_o <= refill_req_i && !done_q && !refill_ack_o && (!slow_i || tick_q == 3'h0);
      done_q <= refill_req_i && (done_q || refill_ack_o);
    end
  end
endmodule // ceh_mem_model

`default_nettype wire

// *** test/tb.sv ***
/*
  Self-checking bench of the correctable error handler.
  Assumes the handler, checker and memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic ic_err_i = 1'b0, ic_double_i = 1'b0, dlm_nonspec_i = 1'b0;
  logic dma_ilm_wr_i = 1'b0, dma_dlm_wr_i = 1'b0;
  logic ic_cnt_clr_i = 1'b0, ilm_cnt_clr_i = 1'b0, dlm_cnt_clr_i = 1'b0;
  logic [7:0] ic_set_i = 8'h00;
  logic [15:0] ic_thresh_i = 16'h0002, ilm_thresh_i = 16'h0000, dlm_thresh_i = 16'h0001;
  ceh_pkg::ceh_err_t ilm_fetch_i = '0, dlm_ls_i = '0, dma_ilm_rd_i = '0, dma_dlm_rd_i = '0;
  logic ic_refill_ack_i, ilm_wb_ready_i, dlm_wb_ready_i;
  logic ic_inv_o, ic_refill_req_o, refetch_pc_flush_o, pipe_flush_o, ilm_refetch_o;
  logic dma_ilm_hold_o, dma_dlm_hold_o, dlm_ls_hold_o, corr_irq_o;
  logic [7:0] ic_inv_set_o;
  logic [31:0] ilm_refetch_addr_o;
  logic [15:0] ic_count_o, ilm_count_o, dlm_count_o;
  ceh_pkg::ceh_wb_t ilm_wb_o, dlm_wb_o;
  int num_errors = 0, comparisons = 0, i;

  always #2.5 clk_i = ~clk_i;

  ceh_handler dut_u (.*);
  ceh_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .refill_req_i(ic_refill_req_o), .ilm_wb_i(ilm_wb_o.valid), .dlm_wb_i(dlm_wb_o.valid),
    .refill_ack_o(ic_refill_ack_i), .ilm_ready_o(ilm_wb_ready_i), .dlm_ready_o(dlm_wb_ready_i));

  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait result; a miss closes the run
  task automatic got(string nm, logic s);
    chk(nm, 32'h1, 32'(s));
    if (s !== 1'b1) end_sim();
  endtask

  task automatic settle;
    for (i = 0; i < 60 && (ic_refill_req_o || ilm_wb_o.valid || dlm_wb_o.valid); i++) step(1);
    got("idle", !(ic_refill_req_o || ilm_wb_o.valid || dlm_wb_o.valid));
    step(4);
  endtask

  task automatic t_icache;
    ic_err_i = 1'b1;
    ic_double_i = 1'b1;
    ic_set_i = 8'h5A;
    step(1);
    ic_err_i = 1'b0;
    chk("ic count", 32'h1, 32'(ic_count_o));
    for (i = 0; i < 8 && !ic_inv_o; i++) step(1);
    got("invalidate", ic_inv_o);
    chk("inv set", 32'h5A, 32'(ic_inv_set_o));
    chk("flushes", 32'h3, 32'({refetch_pc_flush_o, pipe_flush_o}));
    got("refill", ic_refill_req_o);
    settle();
    ic_err_i = 1'b1;
    ic_double_i = 1'b0;
    step(1);
    ic_err_i = 1'b0;
    chk("ic count", 32'h2, 32'(ic_count_o));
    step(1);
    chk("irq", 32'h1, 32'(corr_irq_o));
    settle();
    ic_cnt_clr_i = 1'b1;
    step(1);
    ic_cnt_clr_i = 1'b0;
    step(1);
    chk("irq", 32'h0, 32'(corr_irq_o));
    $display("done icache");
  endtask

  task automatic t_ilm;
    ilm_fetch_i = '{1'b1, 32'h0004_0010, 32'hDEAD_BEEF};
    step(1);
    ilm_fetch_i.err = 1'b0;
    chk("ilm count", 32'h1, 32'(ilm_count_o));
    for (i = 0; i < 8 && !ilm_wb_o.valid; i++) step(1);
    got("ilm wb", ilm_wb_o.valid);
    chk("wb addr", 32'h0004_0010, ilm_wb_o.addr);
    chk("wb data", 32'hDEAD_BEEF, ilm_wb_o.data);
    for (i = 0; i < 20 && !ilm_refetch_o; i++) step(1);
    got("refetch", ilm_refetch_o);
    chk("refetch addr", 32'h0004_0010, ilm_refetch_addr_o);
    chk("irq off", 32'h0, 32'(corr_irq_o));
    settle();
    dma_ilm_wr_i = 1'b1;
    dma_ilm_rd_i = '{1'b1, 32'h0004_0020, 32'h1234_5678};
    step(1);
    chk("dma write", 32'h1, 32'(ilm_count_o));
    chk("dma write wb", 32'h0, 32'(ilm_wb_o.valid));
    dma_ilm_wr_i = 1'b0;
    step(1);
    chk("dma ilm hold", 32'h1, 32'(dma_ilm_hold_o));
    dma_ilm_rd_i.err = 1'b0;
    chk("ilm count", 32'h2, 32'(ilm_count_o));
    got("dma wb", ilm_wb_o.valid);
    chk("dma data", 32'h1234_5678, ilm_wb_o.data);
    chk("wb parity", 32'h0, 32'(^{ilm_wb_o.data, ilm_wb_o.chk}));
    settle();
    // Fetch and DMA errors in one cycle: both counted, DMA written first
    ilm_fetch_i = '{1'b1, 32'h0004_0030, 32'h0F0F_0F0F};
    dma_ilm_rd_i = '{1'b1, 32'h0004_0040, 32'hA5A5_5A5A};
    step(1);
    ilm_fetch_i.err = 1'b0;
    dma_ilm_rd_i.err = 1'b0;
    chk("ilm count", 32'h4, 32'(ilm_count_o));
    chk("dma first", 32'h0004_0040, ilm_wb_o.addr);
    for (i = 0; i < 20 && !ilm_refetch_o; i++) step(1);
    got("refetch", ilm_refetch_o);
    chk("refetch addr", 32'h0004_0030, ilm_refetch_addr_o);
    // Instruction memory threshold raises the interrupt
    ilm_thresh_i = 16'h0004;
    step(1);
    chk("irq", 32'h1, 32'(corr_irq_o));
    ilm_thresh_i = 16'h0000;
    step(1);
    chk("irq off", 32'h0, 32'(corr_irq_o));
    $display("done instr memory");
  endtask

  task automatic t_dlm;
    slow = 1'b1;
    dlm_ls_i = '{1'b1, 32'h0008_0004, 32'hCAFE_F00D};
    step(1);
    chk("dlm spec", 32'h0, 32'(dlm_count_o));
    dlm_nonspec_i = 1'b1;
    step(1);
    chk("ls hold", 32'h1, 32'(dlm_ls_hold_o));
    dlm_ls_i.err = 1'b0;
    chk("dlm count", 32'h1, 32'(dlm_count_o));
    got("dlm wb", dlm_wb_o.valid);
    chk("dlm data", 32'hCAFE_F00D, dlm_wb_o.data);
    step(1);
    chk("irq", 32'h1, 32'(corr_irq_o));
    settle();
    dma_dlm_rd_i = '{1'b1, 32'h0008_0008, 32'h0BAD_CAFE};
    step(1);
    chk("dma dlm hold", 32'h1, 32'(dma_dlm_hold_o));
    dma_dlm_rd_i.err = 1'b0;
    chk("dlm count", 32'h2, 32'(dlm_count_o));
    got("dma wb", dlm_wb_o.valid);
    chk("dma addr", 32'h0008_0008, dlm_wb_o.addr);
    chk("wb parity", 32'h0, 32'(^{dlm_wb_o.data, dlm_wb_o.chk}));
    settle();
    slow = 1'b0;
    $display("done data memory");
  endtask

  task automatic t_sat;
    ic_err_i = 1'b1;
    step(65540);
    chk("saturate", 32'hFFFF, 32'(ic_count_o));
    // Clear and error in one cycle: the error survives
    ic_cnt_clr_i = 1'b1;
    step(1);
    ic_err_i = 1'b0;
    ic_cnt_clr_i = 1'b0;
    chk("clear vs error", 32'h1, 32'(ic_count_o));
    settle();
    $display("done saturation");
  endtask

  initial begin
    step(12);
    rst_i = 1'b0;
    step(1);
    t_icache();
    t_ilm();
    t_dlm();
    t_sat();
    end_sim();
  end
endmodule // tb

`default_nettype wire
